//--- plc_pkg.sv
// Contract
// - After reset, load configuration from EEPROM automatically
// - Legacy enable is bit 6 of register F0
// - Legacy set: ignore key 6A, take 6B, visible
// - Legacy clear: 6A only if load succeeded, else 6B
// - Legacy mode: base, DMA, IRQ from EEPROM
// - Vendor byte loaded from EEPROM word 1A
// - Claim I/O only with base in 200h-3FFh
// - Decode 10 bits for I/O, 12 for config
// - Host leaves 279h, A79h, 203h-3FFh free; select two strobes on 279h and A79h, two/three span 200h-3FFh
// - Host select base 0, control value 0073h
// - Host selects decode I/O space, mode 81B8h
// - Selects two/three at 200h/300h, pins not GPIO
package plc_pkg;
   // ****************************************
   // Configuration protocol ports and registers
   // ****************************************
   localparam logic [11:0] CFG_ADDR_PORT = 12'h279; // Index port
   localparam logic [11:0] CFG_WDATA_PORT = 12'hA79; // Write data port
   localparam logic [11:0] CFG_RDATA_PORT = 12'h20B; // Read data port
   localparam logic [7:0] CTRL_REG = 8'h02; // Control register
   localparam logic [7:0] CTRL_WAIT_KEY = 8'h02; // Return to wait-for-key
   localparam logic [7:0] ACT_REG = 8'h30; // Activate register
   localparam logic [7:0] IOBASE_HI_REG = 8'h60; // I/O base high
   localparam logic [7:0] IOBASE_LO_REG = 8'h61; // I/O base low
   localparam logic [7:0] IRQ_REG = 8'h70; // Interrupt line
   localparam logic [7:0] DMA_REG = 8'h74; // DMA channel
   localparam logic [7:0] VENDOR_REG = 8'hF0; // vendor_config_byte
   localparam int LEGACY_BIT_POS = 6; // legacy_enable_bit
   localparam logic [7:0] VENDOR_RESET = 8'h00; // Vendor byte reset
   // ****************************************
   // Keys and decoding
   // ****************************************
   localparam logic [7:0] KEY_STD_SEED = 8'h6A; // Standard key
   localparam logic [7:0] KEY_VND_SEED = 8'h6B; // Vendor key
   localparam int KEY_LEN = 32; // Bytes per key
   localparam logic [9:0] IO_WIN_LO = 10'h200; // Window low end
   localparam logic [9:0] IO_WIN_HI = 10'h3FF; // Window high end
   localparam int IO_DEC_BITS = 10; // Ordinary I/O decode width
   localparam int CFG_DEC_BITS = 12; // Config decode width
   // ****************************************
   // EEPROM image layout
   // ****************************************
   localparam logic [6:0] EE_IOBASE_WORD = 7'h08; // I/O base word
   localparam logic [6:0] EE_IRQDMA_WORD = 7'h09; // IRQ low, DMA high
   localparam logic [6:0] EE_VENDOR_WORD = 7'h1A; // Vendor byte word
   localparam logic [6:0] EE_LAST_WORD = 7'h1B; // Checksum word
   localparam logic [15:0] EE_BLANK = 16'hFFFF; // Erased word
   localparam logic [15:0] EE_SUM_GOOD = 16'h0000; // Sum of good image
   localparam int EE_TIMEOUT = 64; // Cycles to wait per word
   // ****************************************
   // Host side registers
   // ****************************************
   localparam logic [3:0] H_ADDR = 4'h0; // Target I/O address
   localparam logic [3:0] H_DATA = 4'h1; // Write data
   localparam logic [3:0] H_GO = 4'h2; // Bit0 write, bit1 read
   localparam logic [3:0] H_STAT = 4'h3; // Status and read data
   localparam logic [3:0] H_PSB = 4'h4; // periph_select_base_reg
   localparam logic [3:0] H_PSM = 4'h5; // periph_select_mode_reg
   localparam logic [3:0] H_PIO = 4'h6; // Pin mode register
   localparam logic [15:0] PSB_INIT = 16'h0073; // Base 0, ext ready, 3 ws
   localparam logic [15:0] PSM_INIT = 16'h81B8; // I/O space selects
   localparam logic [15:0] PIO_CS_MASK = 16'h000C; // Select pins as GPIO
   localparam logic [15:0] PSB_RESET = 16'h0000; // Before init
   localparam logic [15:0] PSM_RESET = 16'h0000; // Before init
   localparam logic [15:0] PIO_RESET = 16'h000C; // Pins start as GPIO
   localparam int PSM_IO_BIT = 7; // Select decodes I/O space
   localparam int PSB_NOREADY_BIT = 2; // Zero: external ready needed

   typedef enum {LD_REQ, LD_WAIT, LD_CHECK, LD_RUN} plc_ld_t;
   typedef enum {HS_PSB, HS_PSM, HS_PIO, HS_IDLE, HS_WAIT} plc_hs_t;
endpackage : plc_pkg

//--- plc_if.sv
`timescale 1ns/1ps
// ****************************************
// I/O bus between host and controller
// ****************************************
interface plc_if;
   logic [11:0] addr; // I/O address
   logic wr; // Write strobe, one cycle
   logic rd; // Read strobe, one cycle
   logic [7:0] wdata; // Write data
   logic [7:0] rdata; // Read data, cycle after rd
   logic claim; // Device claims the cycle

   modport dev (input addr, wr, rd, wdata, output rdata, claim);
   modport host (output addr, wr, rd, wdata, input rdata, claim);
endinterface : plc_if

//--- plc_key_detect.sv
`timescale 1ns/1ps
// ****************************************
// Initiation key sequence recognizer
// ****************************************
module plc_key_detect #(
   parameter logic [7:0] SEED = 8'h6A,
   parameter int LEN = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] data,
   output logic hit
);
   logic [7:0] exp_ff; // Expected next key byte
   logic [5:0] cnt_ff; // Bytes matched so far
   logic hit_ff; // One-cycle key recognized

   // Next byte of the key shift sequence
   function automatic logic [7:0] nxt_key(input logic [7:0] b);
      nxt_key = {b[0] ^ b[1], b[7:1]};
   endfunction : nxt_key

   // Match each written byte against the sequence
   always_ff @(posedge clk) begin
      if (rst) begin
         exp_ff <= SEED;
         cnt_ff <= 6'h00;
         hit_ff <= 1'b0;
      end else begin
         hit_ff <= 1'b0;
         if (wr_en) begin
            if (data == exp_ff) begin
               // Last byte completes the key
               if (cnt_ff == 6'(LEN - 1)) begin
                  hit_ff <= 1'b1;
                  cnt_ff <= 6'h00;
                  exp_ff <= SEED;
               end else begin
                  cnt_ff <= cnt_ff + 6'h01;
                  exp_ff <= nxt_key(exp_ff);
               end
            end else if (data == SEED) begin
               // Restart on a fresh seed byte
               cnt_ff <= 6'h01;
               exp_ff <= nxt_key(SEED);
            end else begin
               cnt_ff <= 6'h00;
               exp_ff <= SEED;
            end
         end
      end
   end

   assign hit = hit_ff;
endmodule : plc_key_detect

//--- plc_device.sv
`timescale 1ns/1ps
// ****************************************
// Controller end: EEPROM load, keys, decode
// ****************************************
module plc_device
   import plc_pkg::*;
#(
   parameter int TIMEOUT = EE_TIMEOUT
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   plc_if.dev BUS,
   output logic [6:0] EE_ADDR,
   output logic EE_RD,
   input wire logic EE_VALID,
   input wire logic [15:0] EE_DATA,
   input wire logic EE_PRESENT,
   output logic LOAD_DONE,
   output logic LOAD_OK,
   output logic LEGACY,
   output logic CFG_MODE,
   output logic [3:0] IRQ_LINE,
   output logic [2:0] DMA_CHAN
);
   // ****************************************
   // Declarations
   // ****************************************
   plc_ld_t ld_state_ff; // Load sequencer state
   logic [6:0] ee_addr_ff; // Word being fetched
   logic ee_rd_ff; // Fetch pulse
   logic [15:0] sum_ff; // Running image sum
   logic blank_ff; // Any fetched word erased
   logic [7:0] tmo_ff; // Fetch timeout counter
   logic load_ok_ff; // Image judged good
   logic [9:0] iobase_ff; // Current I/O base
   logic [3:0] irq_ff; // Interrupt line
   logic [2:0] dma_ff; // DMA channel
   logic [7:0] vendor_ff; // vendor_config_byte
   logic active_ff; // Activated by software
   logic cfg_mode_ff; // Key accepted
   logic [7:0] index_ff; // Config register index
   logic [7:0] rdata_ff; // Bus read data
   logic [7:0] regs_ff [16]; // Controller register set
   logic legacy_enable_bit; // Legacy mode flag
   logic std_hit; // Standard key seen
   logic vnd_hit; // Vendor key seen
   logic key_wr; // Write to index port
   logic cfg_wr; // Write to config data port
   logic cfg_rd; // Read of config data port
   logic base_ok; // Base inside window
   logic io_hit; // Ordinary I/O address match
   logic visible; // Answers ordinary I/O
   logic [7:0] cfg_rval; // Selected config value

   assign legacy_enable_bit = vendor_ff[LEGACY_BIT_POS];

   // ****************************************
   // EEPROM load after reset
   // ****************************************
   // Sequencer walks the whole image once
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         ld_state_ff <= LD_REQ;
         ee_addr_ff <= 7'h00;
         ee_rd_ff <= 1'b0;
         tmo_ff <= 8'h00;
      end else begin
         ee_rd_ff <= 1'b0;
         case (ld_state_ff)
            LD_REQ: begin
               // Missing part ends the load at once
               if (!EE_PRESENT) begin
                  ld_state_ff <= LD_CHECK;
               end else begin
                  ee_rd_ff <= 1'b1;
                  tmo_ff <= 8'h00;
                  ld_state_ff <= LD_WAIT;
               end
            end
            LD_WAIT: begin
               // Next word or give up on silence
               if (EE_VALID) begin
                  if (ee_addr_ff == EE_LAST_WORD) begin
                     ld_state_ff <= LD_CHECK;
                  end else begin
                     ee_addr_ff <= ee_addr_ff + 7'h01;
                     ld_state_ff <= LD_REQ;
                  end
               end else if (tmo_ff == 8'(TIMEOUT - 1)) begin
                  ld_state_ff <= LD_CHECK;
               end else begin
                  tmo_ff <= tmo_ff + 8'h01;
               end
            end
            LD_CHECK: begin
               ld_state_ff <= LD_RUN;
            end
            LD_RUN: begin
               ld_state_ff <= LD_RUN;
            end
            default: begin
               ld_state_ff <= LD_REQ;
            end
         endcase
      end
   end

   // Sum and blank check of fetched words
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         sum_ff <= 16'h0000;
         blank_ff <= 1'b0;
         load_ok_ff <= 1'b0;
      end else if (ld_state_ff == LD_WAIT && EE_VALID) begin
         sum_ff <= sum_ff + EE_DATA;
         if (EE_DATA == EE_BLANK) begin
            blank_ff <= 1'b1;
         end
      end else if (ld_state_ff == LD_CHECK) begin
         // Missing, blank, short or corrupt image fails
         load_ok_ff <= EE_PRESENT && !blank_ff && sum_ff == EE_SUM_GOOD &&
            ee_addr_ff == EE_LAST_WORD && tmo_ff != 8'(TIMEOUT - 1);
      end
   end

   // ****************************************
   // Key recognition
   // ****************************************
   assign key_wr = BUS.wr && BUS.addr == CFG_ADDR_PORT;
   assign cfg_wr = cfg_mode_ff && BUS.wr &&
      BUS.addr[CFG_DEC_BITS-1:0] == CFG_WDATA_PORT;
   assign cfg_rd = cfg_mode_ff && BUS.rd &&
      BUS.addr[CFG_DEC_BITS-1:0] == CFG_RDATA_PORT;

   plc_key_detect #(.SEED(KEY_STD_SEED), .LEN(KEY_LEN)) u_key_std (
      .clk(REF_CLK),
      .rst(RESET),
      .wr_en(key_wr && !cfg_mode_ff),
      .data(BUS.wdata),
      .hit(std_hit)
   );

   plc_key_detect #(.SEED(KEY_VND_SEED), .LEN(KEY_LEN)) u_key_vnd (
      .clk(REF_CLK),
      .rst(RESET),
      .wr_en(key_wr && !cfg_mode_ff),
      .data(BUS.wdata),
      .hit(vnd_hit)
   );

   // Config mode entry by allowed key, exit by control write
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         cfg_mode_ff <= 1'b0;
      end else if (ld_state_ff != LD_RUN) begin
         cfg_mode_ff <= 1'b0;
      end else if (vnd_hit) begin
         cfg_mode_ff <= 1'b1;
      end else if (std_hit && !legacy_enable_bit && load_ok_ff) begin
         cfg_mode_ff <= 1'b1;
      end else if (cfg_wr && index_ff == CTRL_REG &&
         BUS.wdata == CTRL_WAIT_KEY) begin
         cfg_mode_ff <= 1'b0;
      end
   end

   // Index register of the config protocol
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         index_ff <= 8'h00;
      end else if (cfg_mode_ff && key_wr) begin
         index_ff <= BUS.wdata;
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   // EEPROM values first, then protocol writes
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         iobase_ff <= 10'h000;
         irq_ff <= 4'h0;
         dma_ff <= 3'h0;
         vendor_ff <= VENDOR_RESET;
         active_ff <= 1'b0;
      end else if (ld_state_ff == LD_WAIT && EE_VALID) begin
         // Fixed resources straight from the image
         if (ee_addr_ff == EE_IOBASE_WORD) begin
            iobase_ff <= EE_DATA[9:0];
         end
         if (ee_addr_ff == EE_IRQDMA_WORD) begin
            irq_ff <= EE_DATA[3:0];
            dma_ff <= EE_DATA[10:8];
         end
         if (ee_addr_ff == EE_VENDOR_WORD) begin
            vendor_ff <= EE_DATA[7:0];
         end
      end else if (ld_state_ff == LD_CHECK && !load_ok_ff &&
         (!EE_PRESENT || blank_ff || sum_ff != EE_SUM_GOOD ||
         ee_addr_ff != EE_LAST_WORD || tmo_ff == 8'(TIMEOUT - 1))) begin
         // Bad image resets the vendor byte, legacy off
         vendor_ff <= VENDOR_RESET;
      end else if (cfg_wr) begin
         case (index_ff)
            IOBASE_HI_REG: iobase_ff[9:8] <= BUS.wdata[1:0];
            IOBASE_LO_REG: iobase_ff[7:0] <= BUS.wdata;
            IRQ_REG: irq_ff <= BUS.wdata[3:0];
            DMA_REG: dma_ff <= BUS.wdata[2:0];
            VENDOR_REG: vendor_ff <= BUS.wdata;
            ACT_REG: active_ff <= BUS.wdata[0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Address decode and data path
   // ****************************************
   assign base_ok = iobase_ff >= IO_WIN_LO && iobase_ff <= IO_WIN_HI;
   assign visible = ld_state_ff == LD_RUN &&
      (legacy_enable_bit || active_ff);
   assign io_hit = visible && base_ok &&
      BUS.addr[IO_DEC_BITS-1:4] == iobase_ff[9:4];

   // Config register read mux
   always_comb begin
      case (index_ff)
         IOBASE_HI_REG: cfg_rval = {6'h00, iobase_ff[9:8]};
         IOBASE_LO_REG: cfg_rval = iobase_ff[7:0];
         IRQ_REG: cfg_rval = {4'h0, irq_ff};
         DMA_REG: cfg_rval = {5'h00, dma_ff};
         VENDOR_REG: cfg_rval = vendor_ff;
         ACT_REG: cfg_rval = {7'h00, active_ff};
         default: cfg_rval = 8'h00;
      endcase
   end

   assign BUS.claim = ((BUS.wr || BUS.rd) && io_hit) ||
      cfg_rd || cfg_wr || (cfg_mode_ff && key_wr);

   // Register set writes
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         for (int i = 0; i < 16; i++) begin
            regs_ff[i] <= 8'h00;
         end
      end else if (BUS.wr && io_hit) begin
         regs_ff[BUS.addr[3:0]] <= BUS.wdata;
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         rdata_ff <= 8'h00;
      end else if (cfg_rd) begin
         rdata_ff <= cfg_rval;
      end else if (BUS.rd && io_hit) begin
         rdata_ff <= regs_ff[BUS.addr[3:0]];
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign BUS.rdata = rdata_ff;
   assign EE_ADDR = ee_addr_ff;
   assign EE_RD = ee_rd_ff;
   assign LOAD_DONE = ld_state_ff == LD_RUN;
   assign LOAD_OK = load_ok_ff;
   assign LEGACY = legacy_enable_bit;
   assign CFG_MODE = cfg_mode_ff;
   assign IRQ_LINE = irq_ff;
   assign DMA_CHAN = dma_ff;
endmodule : plc_device

//--- plc_host.sv
`timescale 1ns/1ps
// ****************************************
// Host end: select setup and I/O cycles
// ****************************************
module plc_host
   import plc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RESET,
   plc_if.host BUS,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   output logic SEL_TWO_N,
   output logic SEL_THREE_N
);
   plc_hs_t hs_ff; // Host sequencer state
   logic [15:0] psb_ff; // periph_select_base_reg
   logic [15:0] psm_ff; // periph_select_mode_reg
   logic [15:0] pio_ff; // Pin mode register
   logic [11:0] addr_ff; // Target address
   logic [7:0] data_ff; // Target write data
   logic [7:0] rbyte_ff; // Last read byte
   logic nack_ff; // Last cycle not claimed
   logic [1:0] ws_ff; // Wait state count
   logic wr_ff; // Bus write strobe
   logic rd_ff; // Bus read strobe
   logic rd_q_ff; // Bus read one cycle ago
   logic [15:0] rdata_ff; // Port read data
   logic init_done; // Setup finished
   logic selects_on; // Select pins usable

   assign init_done = hs_ff == HS_IDLE || hs_ff == HS_WAIT;
   assign selects_on = init_done && psm_ff[PSM_IO_BIT] &&
      (pio_ff & PIO_CS_MASK) == 16'h0000;

   // ****************************************
   // Setup then command sequencer
   // ****************************************
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         hs_ff <= HS_PSB;
         psb_ff <= PSB_RESET;
         psm_ff <= PSM_RESET;
         pio_ff <= PIO_RESET;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         ws_ff <= 2'h0;
      end else begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         case (hs_ff)
            HS_PSB: begin
               psb_ff <= PSB_INIT;
               hs_ff <= HS_PSM;
            end
            HS_PSM: begin
               psm_ff <= PSM_INIT;
               hs_ff <= HS_PIO;
            end
            HS_PIO: begin
               pio_ff <= pio_ff & ~PIO_CS_MASK;
               hs_ff <= HS_IDLE;
            end
            HS_IDLE: begin
               // Launch a cycle on a go write
               if (WR && ADDR == H_GO && (WDATA[0] || WDATA[1])) begin
                  wr_ff <= WDATA[0];
                  rd_ff <= !WDATA[0];
                  ws_ff <= psb_ff[1:0];
                  hs_ff <= HS_WAIT;
               end else if (WR && ADDR == H_PIO) begin
                  pio_ff <= WDATA;
               end
            end
            HS_WAIT: begin
               // Hold off further cycles for the wait states
               if (ws_ff == 2'h0) begin
                  hs_ff <= HS_IDLE;
               end else begin
                  ws_ff <= ws_ff - 2'h1;
               end
            end
            default: begin
               hs_ff <= HS_PSB;
            end
         endcase
      end
   end

   // Address and data staging
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         addr_ff <= 12'h000;
         data_ff <= 8'h00;
      end else if (WR && ADDR == H_ADDR) begin
         addr_ff <= WDATA[11:0];
      end else if (WR && ADDR == H_DATA) begin
         data_ff <= WDATA[7:0];
      end
   end

   // Capture claim and read data; ready required
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         nack_ff <= 1'b0;
         rbyte_ff <= 8'h00;
         rd_q_ff <= 1'b0;
      end else begin
         // Remember the read strobe for the data cycle
         rd_q_ff <= rd_ff;
         if ((wr_ff || rd_ff) && !psb_ff[PSB_NOREADY_BIT]) begin
            nack_ff <= !BUS.claim;
         end
         if (hs_ff == HS_WAIT && rd_q_ff) begin
            rbyte_ff <= BUS.rdata;
         end
      end
   end

   // Port read data, one cycle after the strobe
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         rdata_ff <= 16'h0000;
      end else if (RD) begin
         case (ADDR)
            H_ADDR: rdata_ff <= {4'h0, addr_ff};
            H_DATA: rdata_ff <= {8'h00, data_ff};
            H_STAT: rdata_ff <= {5'h00, nack_ff, init_done,
               hs_ff == HS_WAIT, rbyte_ff};
            H_PSB: rdata_ff <= psb_ff;
            H_PSM: rdata_ff <= psm_ff;
            H_PIO: rdata_ff <= pio_ff;
            default: rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   // ****************************************
   // Bus drive and select pins
   // ****************************************
   assign BUS.addr = addr_ff;
   assign BUS.wdata = data_ff;
   assign BUS.wr = wr_ff;
   assign BUS.rd = rd_ff;
   assign RDATA = rdata_ff;
   assign SEL_TWO_N = !(selects_on && (wr_ff || rd_ff) &&
      addr_ff[9:8] == 2'b10);
   assign SEL_THREE_N = !(selects_on && (wr_ff || rd_ff) &&
      addr_ff[9:8] == 2'b11);
endmodule : plc_host

//--- plc_bus_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Bus checker beside the host-device link
// ****************************************
module plc_bus_monitor (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic [11:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic claim
);
   // One clock domain, reset disables all
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   AST_CLAIM_STROBE: assert property (claim |-> (wr || rd))
      else $error("claim without strobe");
   AST_CLAIM_WINDOW: assert property (claim |-> addr[9])
      else $error("claim outside 200h-3FFh");
   AST_IDLE_ZERO: assert property (rd && !claim |=> rdata == 8'h00)
      else $error("unclaimed read gave data");
   AST_RDATA_CAUSE: assert property (rdata != 8'h00 |-> $past(rd && claim))
      else $error("read data without claimed read");
   AST_WAIT_STATES: assert property ((wr || rd) |=> !(wr || rd) [*3])
      else $error("fewer than 3 wait states");
   AST_ONE_STROBE: assert property (!(wr && rd))
      else $error("read and write at once");
   AST_SETUP_QUIET: assert property ($fell(RESET) |-> !(wr || rd) [*3])
      else $error("strobe during select setup");
   AST_STROBE_PULSE: assert property ($rose(wr) |=> !wr ##1 !rd)
      else $error("write strobe longer than one cycle");
endmodule : plc_bus_monitor

//--- pnp_legacy_config_loader_tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Both ends joined, host port driven
// ****************************************
module pnp_legacy_config_loader_tb_top
   import plc_pkg::*;
;
   logic ref_clk = 1'b0; // System clock
   logic reset = 1'b1; // Sync reset
   logic [6:0] ee_addr; // Word asked for
   logic ee_rd; // Word request
   logic ee_valid = 1'b0; // Word answer
   logic [15:0] ee_data = 16'h0000; // Word value
   logic ee_present = 1'b1; // EEPROM fitted
   logic load_done, load_ok, legacy, cfg_mode; // Device status
   logic [3:0] irq_line; // Interrupt line
   logic [2:0] dma_chan; // DMA channel
   logic [3:0] h_addr = 4'h0; // Host register
   logic [15:0] h_wdata = 16'h0000; // Host write data
   logic h_wr = 1'b0, h_rd = 1'b0; // Host strobes
   logic [15:0] h_rdata; // Host read data
   logic sel_two_n, sel_three_n; // Select outputs
   logic saw2 = 1'b0, saw3 = 1'b0; // Select seen
   logic [15:0] rv; // Last read
   logic [15:0] ee [0:27]; // EEPROM image
   int errors = 0;
   int total_checks = 0;
   plc_if bus ();
   plc_device #(.TIMEOUT(8)) plc_device_inst (.REF_CLK(ref_clk),
      .RESET(reset), .BUS(bus), .EE_ADDR(ee_addr), .EE_RD(ee_rd),
      .EE_VALID(ee_valid), .EE_DATA(ee_data), .EE_PRESENT(ee_present),
      .LOAD_DONE(load_done), .LOAD_OK(load_ok), .LEGACY(legacy),
      .CFG_MODE(cfg_mode), .IRQ_LINE(irq_line), .DMA_CHAN(dma_chan));
   plc_host plc_host_inst (.REF_CLK(ref_clk), .RESET(reset), .BUS(bus),
      .ADDR(h_addr), .WDATA(h_wdata), .WR(h_wr), .RD(h_rd),
      .RDATA(h_rdata), .SEL_TWO_N(sel_two_n), .SEL_THREE_N(sel_three_n));
   plc_bus_monitor plc_bus_monitor_inst (.REF_CLK(ref_clk),
      .RESET(reset), .addr(bus.addr), .wr(bus.wr), .rd(bus.rd),
      .wdata(bus.wdata), .rdata(bus.rdata), .claim(bus.claim));
   // Clock
   always #5 ref_clk = ~ref_clk;
   // EEPROM answers next cycle, data scrambled when idle
   always @(posedge ref_clk) begin
      ee_valid <= ee_rd & ee_present;
      ee_data <= ee_rd ? ee[ee_addr] : ~ee_data;
   end
   // Record select strobes
   always @(posedge ref_clk) begin
      if ((bus.wr | bus.rd) & !sel_two_n) saw2 <= 1'b1;
      if ((bus.wr | bus.rd) & !sel_three_n) saw3 <= 1'b1;
   end
   task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic hw(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      h_addr <= a;
      h_wdata <= d;
      h_wr <= 1'b1;
      @(posedge ref_clk);
      h_wr <= 1'b0;
   endtask : hw
   task automatic hr(input logic [3:0] a);
      @(posedge ref_clk);
      h_addr <= a;
      h_rd <= 1'b1;
      @(posedge ref_clk);
      h_rd <= 1'b0;
      @(negedge ref_clk);
      rv = h_rdata;
   endtask : hr
   // One bus cycle through the host, then status
   task automatic io(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] g);
      hw(H_ADDR, {4'h0, a});
      hw(H_DATA, {8'h00, d});
      hw(H_GO, {14'h0, g});
      repeat (8) @(posedge ref_clk);
      hr(H_STAT);
   endtask : io
   // 32-byte key to the index port
   task automatic key(input logic [7:0] s);
      logic [7:0] b;
      b = s;
      repeat (32) begin
         io(12'h279, b, 2'b01);
         b = {b[0] ^ b[1], b[7:1]};
      end
   endtask : key
   task automatic rst(input logic p);
      @(posedge ref_clk);
      ee_present <= p;
      reset <= 1'b1;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 500 && load_done !== 1'b1; i++) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("load_done", 16'h0001, load_done);
   endtask : rst
   task report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Watchdog
   initial begin
      #200000;
      errors++;
      report_and_stop;
   end
   // Main sequence
   initial begin
      foreach (ee[i]) ee[i] = 16'h0000;
      ee[8] = 16'h0300; // Base 300h
      ee[9] = 16'h050A; // DMA 5, IRQ A
      ee[26] = 16'h0040; // Legacy on
      ee[27] = 16'hF7B6; // Sum to zero
      rst(1'b1);
      chk("load_ok", 16'h0001, load_ok);
      chk("legacy", 16'h0001, legacy);
      chk("irq", 16'h000A, irq_line);
      chk("dma", 16'h0005, dma_chan);
      hr(H_PSB);
      chk("sel_base", 16'h0073, rv);
      hr(H_PSM);
      chk("sel_mode", 16'h81B8, rv);
      hr(H_PIO);
      chk("pin_mode", 16'h0000, rv);
      io(12'h305, 8'h5A, 2'b01);
      io(12'hF05, 8'h00, 2'b10);
      chk("io_read", 16'h005A, rv & 16'h04FF);
      chk("selects", 16'h0001, {saw2, saw3});
      io(12'h105, 8'h00, 2'b10);
      chk("nack", 16'h0400, rv & 16'h0400);
      io(12'h20B, 8'h00, 2'b10);
      chk("sel_two", 16'h0001, saw2);
      key(KEY_STD_SEED);
      chk("cfg_6A_legacy", 16'h0000, cfg_mode);
      key(KEY_VND_SEED);
      chk("cfg_6B_legacy", 16'h0001, cfg_mode);
      io(12'h279, 8'hF0, 2'b01);
      io(12'hA79, 8'h00, 2'b01);
      chk("legacy_clear", 16'h0000, legacy);
      // Base 100h outside the window, then activate
      io(12'h279, 8'h60, 2'b01);
      io(12'hA79, 8'h01, 2'b01);
      io(12'h279, 8'h30, 2'b01);
      io(12'hA79, 8'h01, 2'b01);
      io(12'h20B, 8'h00, 2'b10);
      chk("cfg_read", 16'h0001, rv & 16'h04FF);
      io(12'h105, 8'h00, 2'b10);
      chk("base_window", 16'h0400, rv & 16'h0400);
      io(12'h279, 8'h02, 2'b01);
      io(12'hA79, 8'h02, 2'b01);
      chk("cfg_exit", 16'h0000, cfg_mode);
      key(KEY_STD_SEED);
      chk("cfg_6A_good", 16'h0001, cfg_mode);
      rst(1'b0);
      chk("load_bad", 16'h0000, load_ok);
      key(KEY_STD_SEED);
      chk("cfg_6A_bad", 16'h0000, cfg_mode);
      key(KEY_VND_SEED);
      chk("cfg_6B_bad", 16'h0001, cfg_mode);
      report_and_stop;
   end
endmodule : pnp_legacy_config_loader_tb_top
